// ===== hw/ctmw_ctrl.sv
// Purpose: one channel of transceiver mode, enable, wake and fault control
// Assumes: APB slave, 100 MHz clk, pins synchronised here
// Notes:   analog bus stage outside; this block steers it
// Notes on behaviour
// - power-up starts in off, wake ignored
// - normal only in normal or dev init
// - normal drives tx level, returns bus level
// - early dominant dropped until recessive seen
// - slope control unless bypass bit set
// - receive-only: driver off, receiver on
// - receive-only only in normal or stop
// - wake mode selectable; forced in fail-safe
// - wake hit holds rx low until mode change
// - wake pattern: dom, short gap, dom
// - mode field keeps reading wake after wake
// - rearm by leaving then reselecting wake
// - auto rearm on stop, sleep, fail-safe
// - rearm independent of wake flag clear
// - stop/normal wake: interrupt, status, rx low
// - stop wake leaves chip in stop
// - stop wake enables watchdog if optioned
// - sleep wake requests restart, rx low
// - wake from sleep raises no interrupt
// - tx dominant timeout: driver off, fail flag
// - timeout ends with tx; mode unchanged
// - bus clamp sets fail flag, mode kept
// - enabling time between 8 and 18 us
// - dominant filter between 0.5 and 1.8 us
// - recessive gap limit 0.5 to 10 ms
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module ctmw_ctrl #(
  parameter int WAKE_REC_CYC = ctmw_pkg::WAKE_REC_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // host chip state
  input  wire logic [2:0]  hostMode,
  input  wire logic        devModeActive,
  input  wire logic        watchdogEnabled,
  // controller pins
  input  wire logic        channelTxInput,
  output logic             channelRxOutput,
  // bus stage
  input  wire logic        busRecessive,
  output logic             busBiasEn,
  output logic             busDriverEn,
  output logic             busDriveDom,
  output logic             slopeBypass,
  // host chip events
  output logic             interruptOutN,
  output logic             watchdogAutoEn,
  output logic             restartReq
);
  // ==========================================================
  // declarations
  ctmw_pkg::ctmw_host_t host;
  logic [1:0]  modeField_r;
  logic        slope_r;
  logic        wdOnWake_r;
  logic [15:0] txToLim_r;
  logic [15:0] busToLim_r;
  logic        busWakeFlag_r;
  logic        failFlag_r;
  logic        intPend_r;
  logic        wakeLatched_r;
  logic        wakeArmed_r;
  logic [1:0]  syncA_r;
  logic [1:0]  syncB_r;
  logic        txRec;
  logic        busDom;
  logic [1:0]  effMode;
  logic [9:0]  enCnt_r;
  logic        enDone;
  logic        txGate_r;
  logic        txOver;
  logic        busOver;
  logic        busOverD_r;
  ctmw_pkg::ctmw_host_t hostD_r;
  logic        wrEn;
  logic        rdEn;
  logic        mapped;
  logic [1:0]  wrMode;
  logic        wakeHit;
  ctmw_wake_if wk ();

  localparam logic [9:0] EN_CYC = 10'(ctmw_pkg::ENABLE_CYC);

  // ==========================================================
  // mode availability per host chip mode
  function automatic logic modeOk(input logic [1:0] m,
                                  input ctmw_pkg::ctmw_host_t h,
                                  input logic dev);
    logic ok;
    ok = 1'b0;
    unique case (m)
      ctmw_pkg::MODE_OFF:  ok = 1'b1;
      ctmw_pkg::MODE_NORM: ok = (h == ctmw_pkg::HM_NORMAL) ||
                                ((h == ctmw_pkg::HM_INIT) && dev);
      ctmw_pkg::MODE_RXO:  ok = (h == ctmw_pkg::HM_NORMAL) ||
                                (h == ctmw_pkg::HM_STOP);
      ctmw_pkg::MODE_WAKE: ok = (h == ctmw_pkg::HM_STOP) ||
                                (h == ctmw_pkg::HM_SLEEP) ||
                                (h == ctmw_pkg::HM_RESTART) ||
                                (h == ctmw_pkg::HM_NORMAL) ||
                                (h == ctmw_pkg::HM_FAILSAFE);
    endcase
    return ok;
  endfunction

  assign host = ctmw_pkg::ctmw_host_t'(hostMode);

  // ==========================================================
  // pin synchronisers, two stages each
  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncA_r <= 2'h3;
      syncB_r <= 2'h3;
    end else begin
      syncA_r <= {busRecessive, channelTxInput};
      syncB_r <= syncA_r;
    end
  end
  assign txRec  = syncB_r[0];
  assign busDom = !syncB_r[1];

  // ==========================================================
  // apb decode; zero wait states
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr == ctmw_pkg::OFS_CTRL)   || (paddr == ctmw_pkg::OFS_WAKE_A) ||
                   (paddr == ctmw_pkg::OFS_WAKE_B) || (paddr == ctmw_pkg::OFS_TXTO)   ||
                   (paddr == ctmw_pkg::OFS_BUSTO)  || (paddr == ctmw_pkg::OFS_STATE);
  assign pslverr = psel && penable && !mapped;
  assign wrMode  = pwdata[ctmw_pkg::CTRL_MODE_LSB +: 2];

  // ==========================================================
  // control register; a refused mode keeps the old field
  always_ff @(posedge clk) begin
    if (!resetn) begin
      modeField_r <= ctmw_pkg::MODE_OFF;
      slope_r     <= 1'b0;
      wdOnWake_r  <= 1'b0;
    end else begin
      if (wrEn && paddr == ctmw_pkg::OFS_CTRL) begin
        slope_r    <= pwdata[ctmw_pkg::CTRL_SLOPE];
        wdOnWake_r <= pwdata[ctmw_pkg::CTRL_WDWAKE];
        if (modeOk(wrMode, host, devModeActive)) begin
          modeField_r <= wrMode;
        end
      end
      if (host == ctmw_pkg::HM_FAILSAFE) begin
        modeField_r <= ctmw_pkg::MODE_WAKE;
      end
    end
  end

  // ==========================================================
  // timeout thresholds
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txToLim_r  <= ctmw_pkg::TXTO_RST;
      busToLim_r <= ctmw_pkg::BUSTO_RST;
    end else if (wrEn) begin
      if (paddr == ctmw_pkg::OFS_TXTO)  txToLim_r  <= pwdata[15:0];
      if (paddr == ctmw_pkg::OFS_BUSTO) busToLim_r <= pwdata[15:0];
    end
  end

  // ==========================================================
  // effective mode: a field the host mode no longer allows acts as off
  assign effMode = modeOk(modeField_r, host, devModeActive) ? modeField_r
                                                            : ctmw_pkg::MODE_OFF;

  // ==========================================================
  // enabling delay, restarted by every normal-mode write
  always_ff @(posedge clk) begin
    if (!resetn || effMode != ctmw_pkg::MODE_NORM) begin
      enCnt_r <= 10'h000;
    end else if (wrEn && paddr == ctmw_pkg::OFS_CTRL && wrMode == ctmw_pkg::MODE_NORM) begin
      enCnt_r <= 10'h000;
    end else if (enCnt_r != EN_CYC) begin
      enCnt_r <= enCnt_r + 10'h001;
    end
  end
  assign enDone = (enCnt_r == EN_CYC);

  // ==========================================================
  // transmit gate opens on recessive after enabling
  always_ff @(posedge clk) begin
    if (!resetn || !enDone) begin
      txGate_r <= 1'b0;
    end else if (txRec) begin
      txGate_r <= 1'b1;
    end
  end

  // ==========================================================
  // dominant timers; tx timer only counts while transmitting
  ctmw_dom_timer uTxTo (
    .clk    (clk),
    .resetn (resetn),
    .dom    (txGate_r && !txRec),
    .limit  (txToLim_r),
    .over   (txOver)
  );
  ctmw_dom_timer uBusTo (
    .clk    (clk),
    .resetn (resetn),
    .dom    (busDom),
    .limit  (busToLim_r),
    .over   (busOver)
  );

  // ==========================================================
  // bus stage outputs, registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busBiasEn   <= 1'b0;
      busDriverEn <= 1'b0;
      busDriveDom <= 1'b0;
      slopeBypass <= 1'b0;
    end else begin
      busBiasEn   <= (effMode == ctmw_pkg::MODE_NORM) || (effMode == ctmw_pkg::MODE_RXO);
      busDriverEn <= (effMode == ctmw_pkg::MODE_NORM) && txGate_r && !txOver;
      busDriveDom <= (effMode == ctmw_pkg::MODE_NORM) && txGate_r && !txOver && !txRec;
      slopeBypass <= slope_r;
    end
  end

  // ==========================================================
  // receive output
  always_ff @(posedge clk) begin
    if (!resetn) begin
      channelRxOutput <= 1'b1;
    end else begin
      unique case (effMode)
        ctmw_pkg::MODE_NORM, ctmw_pkg::MODE_RXO: channelRxOutput <= !busDom;
        ctmw_pkg::MODE_WAKE:                     channelRxOutput <= !wakeLatched_r;
        default:                                 channelRxOutput <= 1'b1;
      endcase
    end
  end

  // ==========================================================
  // wake detector
  assign wk.busDom = busDom;
  assign wk.enable = (effMode == ctmw_pkg::MODE_WAKE) && wakeArmed_r;
  ctmw_wake_det #(
    .REC_CYC (WAKE_REC_CYC)
  ) uWake (
    .clk    (clk),
    .resetn (resetn),
    .wk     (wk)
  );
  assign wakeHit = wk.hit;

  // ==========================================================
  // arming and wake latch; mode field untouched by a wake
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hostD_r       <= ctmw_pkg::HM_INIT;
      wakeLatched_r <= 1'b0;
      wakeArmed_r   <= 1'b1;
    end else begin
      hostD_r <= host;
      if (modeField_r != ctmw_pkg::MODE_WAKE) begin
        wakeLatched_r <= 1'b0;
        wakeArmed_r   <= 1'b1;
      end else if (wakeHit) begin
        wakeLatched_r <= 1'b1;
        wakeArmed_r   <= 1'b0;
      end else if (host != hostD_r && (host == ctmw_pkg::HM_STOP ||
               host == ctmw_pkg::HM_SLEEP || host == ctmw_pkg::HM_FAILSAFE)) begin
        wakeArmed_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // wake reactions on host chip
  always_ff @(posedge clk) begin
    if (!resetn) begin
      watchdogAutoEn <= 1'b0;
      restartReq     <= 1'b0;
    end else begin
      watchdogAutoEn <= wakeHit && host == ctmw_pkg::HM_STOP &&
                        wdOnWake_r && !watchdogEnabled;
      restartReq     <= wakeHit && (host == ctmw_pkg::HM_SLEEP || host == ctmw_pkg::HM_FAILSAFE);
    end
  end

  // ==========================================================
  // sticky flags, write one to clear, a set beats the clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busWakeFlag_r <= 1'b0;
      intPend_r     <= 1'b0;
      failFlag_r    <= 1'b0;
      busOverD_r    <= 1'b0;
    end else begin
      busOverD_r <= busOver;
      if (wakeHit) begin
        busWakeFlag_r <= 1'b1;
      end else if (wrEn && paddr == ctmw_pkg::OFS_WAKE_A && pwdata[ctmw_pkg::WAKE_FLAG]) begin
        busWakeFlag_r <= 1'b0;
      end
      if (wakeHit && (host == ctmw_pkg::HM_STOP || host == ctmw_pkg::HM_NORMAL)) begin
        intPend_r <= 1'b1;
      end else if (wrEn && paddr == ctmw_pkg::OFS_WAKE_A && pwdata[ctmw_pkg::WAKE_FLAG]) begin
        intPend_r <= 1'b0;
      end
      if ((txOver && !busDriverEn && txGate_r) || (busOver && !busOverD_r)) begin
        failFlag_r <= 1'b1;
      end else if (wrEn && paddr == ctmw_pkg::OFS_WAKE_B && pwdata[ctmw_pkg::FAIL_FLAG]) begin
        failFlag_r <= 1'b0;
      end
    end
  end
  assign interruptOutN = !intPend_r;

  // ==========================================================
  // read data, registered at the setup cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (rdEn && !penable) begin
      unique case (paddr)
        ctmw_pkg::OFS_CTRL:   prdata <= {28'h0000000, wdOnWake_r, slope_r, modeField_r};
        ctmw_pkg::OFS_WAKE_A: prdata <= {31'h00000000, busWakeFlag_r};
        ctmw_pkg::OFS_WAKE_B: prdata <= {31'h00000000, failFlag_r};
        ctmw_pkg::OFS_TXTO:   prdata <= {16'h0000, txToLim_r};
        ctmw_pkg::OFS_BUSTO:  prdata <= {16'h0000, busToLim_r};
        ctmw_pkg::OFS_STATE:  prdata <= {24'h000000, busOver, txOver, txGate_r, enDone,
                                         wakeArmed_r, wakeLatched_r, effMode};
        default:              prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ===== hw/ctmw_pkg.sv
// Purpose: shared constants of the transceiver mode and wake control
// Assumes: 100 MHz clock, APB registers one aligned word each
// Notes:   all times in ns, cycle counts derived from the clock period
package ctmw_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int ENABLE_TIME_NS   = 8000;    // transceiver enabling time, least
  localparam int ENABLE_CYC       = (ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_FILT_NS     = 1800;    // dominant filter, longest
  localparam int WAKE_FILT_CYC    = WAKE_FILT_NS / CLK_PERIOD_NS;
  localparam int WAKE_REC_NS      = 10000000; // recessive gap limit, longest
  localparam int WAKE_REC_CYC     = WAKE_REC_NS / CLK_PERIOD_NS;
  localparam int CNT_W            = 20;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WAKE_A = 8'h04;
  localparam logic [7:0] OFS_WAKE_B = 8'h08;
  localparam logic [7:0] OFS_TXTO   = 8'h0c;
  localparam logic [7:0] OFS_BUSTO  = 8'h10;
  localparam logic [7:0] OFS_STATE  = 8'h14;
  // ==========================================================
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SLOPE    = 2;
  localparam int CTRL_WDWAKE   = 3;
  localparam int WAKE_FLAG     = 0;
  localparam int FAIL_FLAG     = 0;
  // ==========================================================
  // transceiver mode field codes
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_RXO  = 2'h2;
  localparam logic [1:0] MODE_NORM = 2'h3;
  // ==========================================================
  // reset values
  localparam logic [15:0] TXTO_RST  = 16'h0fa0;
  localparam logic [15:0] BUSTO_RST = 16'h0fa0;
  // host chip modes, as driven on hostMode
  typedef enum logic [2:0] {
    HM_INIT, HM_NORMAL, HM_STOP, HM_SLEEP, HM_RESTART, HM_FAILSAFE
  } ctmw_host_t;
endpackage

// ===== hw/ctmw_wake_if.sv
// Purpose: carrier between mode control and wake pattern detector
// Assumes: both ends on the one clock
// Notes:   hit is a one-cycle pulse
`timescale 1ns/1ps
interface ctmw_wake_if;
  logic busDom;
  logic enable;
  logic hit;
  modport det (input busDom, input enable, output hit);
  modport ctl (output busDom, output enable, input hit);
endinterface

// ===== hw/ctmw_dom_timer.sv
// Purpose: counts a dominant level and flags it past a threshold
// Assumes: dom already synchronised
// Notes:   flag falls as soon as dom ends
`timescale 1ns/1ps
module ctmw_dom_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // level and limit
  input  wire logic        dom,
  input  wire logic [15:0] limit,
  // result
  output logic             over
);
  logic [15:0] cnt_r;
  // ==========================================================
  // saturating counter, over once count passes limit
  always_ff @(posedge clk) begin
    if (!resetn || !dom) begin
      cnt_r <= 16'h0000;
      over  <= 1'b0;
    end else begin
      if (cnt_r != 16'hffff) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      over <= (cnt_r >= limit);
    end
  end
endmodule

// ===== hw/ctmw_wake_det.sv
// Purpose: detects the two-phase wake pattern on the bus
// Assumes: busDom synchronised, enable low outside wake mode
// Notes:   a short second dominant restarts the search
`timescale 1ns/1ps
module ctmw_wake_det #(
  parameter int REC_CYC = ctmw_pkg::WAKE_REC_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // link to control
  ctmw_wake_if.det  wk
);
  typedef enum logic [1:0] {ST_IDLE, ST_DOM1, ST_GAP, ST_DOM2} ctmw_wst_t;
  localparam logic [19:0] FILT = 20'(ctmw_pkg::WAKE_FILT_CYC);
  localparam logic [19:0] REC  = 20'(REC_CYC);
  ctmw_wst_t   st_r;
  logic [19:0] cnt_r;
  // ==========================================================
  // pattern walk: dom > filter, gap < limit, dom > filter
  always_ff @(posedge clk) begin
    if (!resetn || !wk.enable) begin
      st_r   <= ST_IDLE;
      cnt_r  <= 20'h00000;
      wk.hit <= 1'b0;
    end else begin
      wk.hit <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          cnt_r <= 20'h00000;
          if (wk.busDom) begin
            st_r <= ST_DOM1;
          end
        end
        ST_DOM1: begin
          if (wk.busDom) begin
            if (cnt_r <= FILT) cnt_r <= cnt_r + 20'h00001;
          end else begin
            cnt_r <= 20'h00000;
            st_r  <= (cnt_r > FILT) ? ST_GAP : ST_IDLE;
          end
        end
        ST_GAP: begin
          if (wk.busDom) begin
            cnt_r <= 20'h00000;
            st_r  <= ST_DOM2;
          end else if (cnt_r >= REC) begin
            st_r <= ST_IDLE; // gap too long, start over
          end else begin
            cnt_r <= cnt_r + 20'h00001;
          end
        end
        ST_DOM2: begin
          if (!wk.busDom) begin
            st_r <= ST_IDLE;
          end else if (cnt_r > FILT) begin
            wk.hit <= 1'b1;
            st_r   <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 20'h00001;
          end
        end
      endcase
    end
  end
endmodule

// ===== bench/ctmw_ctrl_props.sv
// Purpose: port checker for one channel control block
// Assumes: one clock, synchronous active-low reset
// Notes:   watches top ports only, bound below
`timescale 1ns/1ps
module ctmw_ctrl_props (
  // clock, reset, apb
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  // host state and pins
  input wire logic [2:0] hostMode,
  input wire logic       watchdogEnabled,
  input wire logic       channelTxInput,
  input wire logic       channelRxOutput,
  input wire logic       busBiasEn,
  input wire logic       busDriverEn,
  input wire logic       busDriveDom,
  input wire logic       interruptOutN,
  input wire logic       watchdogAutoEn,
  input wire logic       restartReq
);
  // ==========================================
  // helpers
  logic       ctrlWr;
  logic [9:0] quiet_r;
  logic [2:0] hostPrev_r;
  assign ctrlWr = psel && penable && pwrite && paddr == 8'h00;
  // host mode one cycle back
  always_ff @(posedge clk) hostPrev_r <= hostMode;
  // cycles since a mode write or host change; saturates, so no wrap
  always_ff @(posedge clk) begin
    if (!resetn || ctrlWr || hostMode != hostPrev_r) quiet_r <= 10'h000;
    else if (quiet_r != 10'h3ff) quiet_r <= quiet_r + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // properties
  property p_off_start;
    $rose(resetn) |-> !busBiasEn && !busDriverEn && channelRxOutput;
  endproperty
  a_off_start: assert property (p_off_start) else $error("not off after reset");
  property p_drv_bias;
    busDriverEn |-> busBiasEn;
  endproperty
  a_drv_bias: assert property (p_drv_bias) else $error("driver without bias");
  property p_tx_rec;
    $rose(channelTxInput) |-> ##[1:5] !busDriveDom;
  endproperty
  a_tx_rec: assert property (p_tx_rec) else $error("recessive not followed");
  property p_enable;
    busDriverEn && busDriveDom |-> quiet_r >= ctmw_pkg::ENABLE_CYC;
  endproperty
  a_enable: assert property (p_enable) else $error("dominant inside enabling time");
  property p_int_src;
    $fell(interruptOutN) |-> hostMode == ctmw_pkg::HM_NORMAL || hostMode == ctmw_pkg::HM_STOP;
  endproperty
  a_int_src: assert property (p_int_src) else $error("interrupt in wrong host mode");
  property p_rx_hold;
    !channelRxOutput && !busBiasEn && quiet_r > 10'h004 |=> !channelRxOutput;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("wake low released early");
  property p_restart;
    restartReq |-> interruptOutN && hostMode inside {3'h3, 3'h5} ##1 !restartReq;
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart pulse");
  property p_wd_auto;
    watchdogAutoEn |-> hostMode == ctmw_pkg::HM_STOP && !watchdogEnabled ##1 !watchdogAutoEn;
  endproperty
  a_wd_auto: assert property (p_wd_auto) else $error("bad watchdog pulse");
endmodule
bind ctmw_ctrl ctmw_ctrl_props i_ctmw_ctrl_props (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .hostMode, .watchdogEnabled, .channelTxInput, .channelRxOutput, .busBiasEn, .busDriverEn,
  .busDriveDom, .interruptOutN, .watchdogAutoEn, .restartReq);

// ===== bench/ctmw_bus_model.sv
// Purpose: bus wire seen by one channel
// Assumes: other nodes only pull dominant
// Notes:   the wire reads recessive whenever nobody drives; bias is not modelled
`timescale 1ns/1ps
module ctmw_bus_model (
  // this channel's driver
  input wire logic drvEn,
  input wire logic drvDom,
  // rest of the network
  input wire logic otherDom,
  // comparator output
  output logic     busRecessive
);
  // wired bus: any dominant wins
  assign busRecessive = !(drvEn && drvDom) && !otherDom;
endmodule

// ===== bench/tb_top.sv
// Purpose: self-checking bench for one channel
// Assumes: zero-wait apb slave, short gap limit
// Notes:   random tx bits from a fixed lfsr seed
`timescale 1ns/1ps
module tb_top;
  // ==========================================
  // ports and bench state
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv, rnd = 32'h5cdcabdf;
  logic [2:0]  hostMode = 3'h1;
  logic        devModeActive = 0, watchdogEnabled = 1, channelTxInput = 1, extDom = 0;
  logic        pready, pslverr, channelRxOutput, busRecessive, busBiasEn, busDriverEn, errSeen;
  logic        busDriveDom, slopeBypass, interruptOutN, watchdogAutoEn, restartReq;
  int          nErrors = 0, checks = 0, nWd = 0, nRst = 0, k, r;
  // short gap limit keeps wake runs brief
  ctmw_ctrl #(.WAKE_REC_CYC(2000)) i_ctmw_ctrl (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hostMode, .devModeActive, .watchdogEnabled,
    .channelTxInput, .channelRxOutput, .busRecessive, .busBiasEn, .busDriverEn, .busDriveDom,
    .slopeBypass, .interruptOutN, .watchdogAutoEn, .restartReq);
  ctmw_bus_model i_ctmw_bus_model (.drvEn(busDriverEn), .drvDom(busDriveDom), .otherDom(extDom),
    .busRecessive);
  // 100 MHz clock
  always #5 clk = ~clk;
  // count one-cycle pulses
  always @(posedge clk) begin
    if (watchdogAutoEn === 1'b1) nWd++;
    if (restartReq === 1'b1) nRst++;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] allow(input int m, input int h, input int d);
    if (m == 3) return (h == 1 || (h == 0 && d == 1)) ? 3 : 0;
    if (m == 2) return (h == 1 || h == 2) ? 2 : 0;
    return (h >= 1 && h <= 4) ? 1 : 0;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; an idle edge follows so back-to-back calls stay clean
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1;
    cyc(1);
    while (pready !== 1'b1) cyc(1);
    rdv = prdata;
    errSeen = pslverr;
    psel <= 0;
    penable <= 0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    apb(0, a, 0);
    chk(n, e, rdv & m);
  endtask
  // two dominant phases around a gap
  task automatic pat(input int d1, input int g, input int d2);
    extDom <= 1;
    cyc(d1);
    extDom <= 0;
    cyc(g);
    extDom <= 1;
    cyc(d2);
    extDom <= 0;
    cyc(20);
  endtask
  task automatic give_verdict;
    if (nErrors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    cyc(6);
    resetn <= 1;
    cyc(1);
    rd(8'h00, 3, 0, "mode");
    rd(8'h0c, 32'hffff, ctmw_pkg::TXTO_RST, "txto");
    rd(8'h10, 32'hffff, ctmw_pkg::BUSTO_RST, "busto");
    rd(8'h18, 32'hffffffff, 0, "unmapped");
    chk("slverr", 1, errSeen);
    chk("bias rst", 0, busBiasEn);
    chk("slope rst", 0, slopeBypass);
    for (int h = 0; h < 5; h++)
      for (int m = 1; m < 4; m++)
        for (int d = 0; d < 2; d++) begin
          hostMode <= 3'(h);
          devModeActive <= 1'(d);
          apb(1, 8'h00, 0);
          apb(1, 8'h00, m);
          rd(8'h00, 3, allow(m, h, d), "mode table");
        end
    hostMode <= 3'h5;
    cyc(3);
    rd(8'h00, 3, 1, "failsafe");
    hostMode <= 3'h1;
    apb(1, 8'h0c, 100);
    apb(1, 8'h10, 300);
    rnd = lfsr(rnd);
    apb(1, 8'h00, {rnd[2], 2'h3});
    channelTxInput <= 0;
    cyc(850);
    chk("early dom", 0, busDriveDom);
    chk("slope", rnd[2], slopeBypass);
    channelTxInput <= 1;
    cyc(5);
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      channelTxInput <= rnd[0];
      cyc(8);
      chk("drive", !rnd[0], busDriveDom);
      chk("receive", rnd[0], channelRxOutput);
      cyc(2);
    end
    channelTxInput <= 0;
    cyc(200);
    chk("txto drv", 0, busDriverEn);
    rd(8'h08, 1, 1, "txto flag");
    channelTxInput <= 1;
    cyc(6);
    chk("drv back", 1, busDriverEn);
    rd(8'h00, 3, 3, "txto mode");
    // state: live normal, gate open, armed, no timeouts
    rd(8'h14, 32'hff, 32'h3b, "state");
    apb(1, 8'h08, 1);
    apb(1, 8'h00, 2);
    channelTxInput <= 0;
    extDom <= 1;
    cyc(8);
    chk("rxo drv", 0, busDriverEn);
    chk("rxo rx", 0, channelRxOutput);
    chk("rxo bias", 1, busBiasEn);
    channelTxInput <= 1;
    apb(1, 8'h00, 0);
    cyc(400);
    chk("off bias", 0, busBiasEn);
    extDom <= 0;
    rd(8'h08, 1, 1, "clamp flag");
    rd(8'h00, 3, 0, "clamp mode");
    apb(1, 8'h08, 1);
    apb(1, 8'h00, 1);
    pat(250, 2600, 250);
    pat(120, 500, 120);
    chk("no wake", 1, channelRxOutput);
    pat(250, 500, 250);
    chk("wake rx", 0, channelRxOutput);
    chk("wake int", 0, interruptOutN);
    rd(8'h04, 1, 1, "wake flag");
    rd(8'h00, 3, 1, "wake field");
    apb(1, 8'h00, 0);
    apb(1, 8'h00, 1);
    chk("rx free", 1, channelRxOutput);
    apb(1, 8'h04, 1);
    pat(250, 500, 250);
    chk("rearmed", 0, interruptOutN);
    hostMode <= 3'h2;
    watchdogEnabled <= 0;
    apb(1, 8'h04, 1);
    apb(1, 8'h00, 9);
    k = nWd;
    r = nRst;
    pat(250, 500, 250);
    chk("wd auto", k + 1, nWd);
    chk("stop int", 0, interruptOutN);
    chk("stop stays", r, nRst);
    hostMode <= 3'h3;
    apb(1, 8'h04, 1);
    pat(250, 500, 250);
    chk("restart", r + 1, nRst);
    chk("sleep int", 1, interruptOutN);
    chk("sleep rx", 0, channelRxOutput);
    // fail-safe entry rearms; wake asks for restart, no interrupt
    hostMode <= 3'h5;
    pat(250, 500, 250);
    chk("failsafe restart", r + 2, nRst);
    chk("failsafe int", 1, interruptOutN);
    give_verdict();
  end
  // watchdog: the run needs about 11k cycles, allow well over three times that
  initial begin
    cyc(40000);
    nErrors++;
    give_verdict();
  end
endmodule
